// ---- verilog/ecd_pkg.sv ----
package ecd_pkg;

   // ==========================================================
   // Command byte layout
   localparam int unsigned OPC_W   = 3;
   localparam int unsigned ARG_W   = 5;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned BANK_W  = 2;
   localparam int unsigned PTR_W   = 13;

   localparam logic [2:0] OPC_REG_READ  = 3'h0;
   localparam logic [2:0] OPC_BUF_READ  = 3'h1;
   localparam logic [2:0] OPC_REG_WRITE = 3'h2;
   localparam logic [2:0] OPC_BUF_WRITE = 3'h3;
   localparam logic [2:0] OPC_BIT_SET   = 3'h4;
   localparam logic [2:0] OPC_BIT_CLEAR = 3'h5;
   localparam logic [2:0] OPC_SOFT_RST  = 3'h7;

   localparam logic [4:0] ARG_BUF       = 5'h1A;
   localparam logic [4:0] ARG_SOFT_RST  = 5'h1F;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [7:0] DUMMY_BYTE    = 8'h00;

   // ==========================================================
   // Buffer pointer limits and pointer register offsets (bank 0)
   localparam logic [12:0] PTR_TOP      = 13'h1FFF;
   localparam logic [12:0] PTR_ZERO     = 13'h0000;
   localparam logic [12:0] PTR_ONE      = 13'h0001;
   localparam logic [1:0]  PTR_BANK     = 2'h0;
   localparam logic [4:0]  OFS_RD_LO    = 5'h00;
   localparam logic [4:0]  OFS_RD_HI    = 5'h01;
   localparam logic [4:0]  OFS_WR_LO    = 5'h02;
   localparam logic [4:0]  OFS_WR_HI    = 5'h03;
   localparam logic [4:0]  OFS_RXS_LO   = 5'h08;
   localparam logic [4:0]  OFS_RXS_HI   = 5'h09;
   localparam logic [4:0]  OFS_RXE_LO   = 5'h0A;
   localparam logic [4:0]  OFS_RXE_HI   = 5'h0B;

   // Reset values of the buffer pointers.
   localparam logic [12:0] RST_RD_PTR   = 13'h0000;
   localparam logic [12:0] RST_WR_PTR   = 13'h0000;
   localparam logic [12:0] RST_RXS      = 13'h0000;
   localparam logic [12:0] RST_RXE      = 13'h1FFF;

   // ==========================================================
   // Frame phases, one-hot
   typedef enum logic [3:0] {
      PH_CMD   = 4'h1,
      PH_DUMMY = 4'h2,
      PH_DATA  = 4'h4,
      PH_IDLE  = 4'h8
   } ecd_phase_t;

   // Register update as seen by the system side.
   typedef struct packed {
      logic [1:0] bank;
      logic [4:0] addr;
      logic [7:0] value;
   } ecd_update_t;

   localparam int unsigned UPD_W = 15;

endpackage

// ---- verilog/ecd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser; the first stage feeds only the second.
module ecd_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ==========================================================
   // Stages
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

`default_nettype wire

// ---- verilog/ecd_event_xfer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Carries one event with a word from the link clock to the system clock.
// The word is held until the next event, so events must be at least four
// system clocks apart; one byte on the link always is.
module ecd_event_xfer #(
   parameter int unsigned WIDTH = 8
) (
   // Reset, common to both sides
   input  wire logic             reset,
   // Source side
   input  wire logic             clk_src,
   input  wire logic             src_fire,
   input  wire logic [WIDTH-1:0] src_data,
   // Destination side
   input  wire logic             clk_dst,
   output logic                  dst_valid,
   output logic      [WIDTH-1:0] dst_data
);

   logic             tgl_q,   tgl_d;
   logic [WIDTH-1:0] hold_q,  hold_d;
   logic             tgl_s;
   logic             seen_q;
   logic             vld_q,   vld_d;
   logic [WIDTH-1:0] out_q,   out_d;

   // ==========================================================
   // Source: flip the toggle and hold the word.
   always_comb begin
      tgl_d  = src_fire ? ~tgl_q : tgl_q;
      hold_d = src_fire ? src_data : hold_q;
   end

   always_ff @(posedge clk_src or posedge reset) begin
      if (reset) begin
         tgl_q  <= 1'b0;
         hold_q <= '0;
      end else begin
         tgl_q  <= tgl_d;
         hold_q <= hold_d;
      end
   end

   ecd_sync #(.WIDTH(1)) u_tgl_sync (
      .clk   (clk_dst),
      .reset (reset),
      .d     (tgl_q),
      .q     (tgl_s)
   );

   // ==========================================================
   // Destination: a change of the synced toggle is one event.
   always_comb begin
      vld_d = tgl_s ^ seen_q;
      out_d = vld_d ? hold_q : out_q;
   end

   always_ff @(posedge clk_dst or posedge reset) begin
      if (reset) begin
         seen_q <= 1'b0;
         vld_q  <= 1'b0;
         out_q  <= '0;
      end else begin
         seen_q <= tgl_s;
         vld_q  <= vld_d;
         out_q  <= out_d;
      end
   end

   assign dst_valid = vld_q;
   assign dst_data  = out_q;

endmodule

`default_nettype wire

// ---- verilog/ecd_spi_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] Byte zero: 3-bit opcode, 5-bit argument.
// [R2] Sample on rising clock, drive on falling.
// [R3] Host frames every command with chip select.
// [R4] Argument picks one of 32 registers in bank.
// [R5] Core register read data follows argument directly.
// [R6] Other register reads send one dummy first.
// [R7] Host sends 1Ah argument for buffer commands.
// [R8] Buffer read streams bytes while select stays low.
// [R9] Auto-step read pointer after each byte.
// [R10] Read pointer at ring end reloads ring start.
// [R11] Read pointer wraps 1FFFh to 0000h otherwise.
// [R12] Register write stores byte on its last bit.
// [R13] Partial register write byte is discarded.
// [R14] Buffer write stores byte, then steps pointer.
// [R15] Write pointer wraps 1FFFh to 0000h.
// [R16] Buffer writes continue while select stays low.
// [R17] Bit set ORs data on bit zero.
// [R18] Bit clear ANDs inverted data on bit zero.
// [R19] Host uses set and clear on core registers.
// [R20] Partial set or clear byte is aborted.
// [R21] One-byte soft reset command, argument all ones.
// [R22] Registers accessible in any order.
// [R23] Bank and class map decide dummy byte; here only the class bit of the argument does, whatever the bank.
module ecd_spi_decoder #(
   parameter int unsigned MEM_DEPTH = 8192,
   parameter int unsigned NUM_BANKS = 4
) (
   // System clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        reset,
   // Configuration from the system side
   input  wire logic [ecd_pkg::BANK_W-1:0]  bank_sel,
   input  wire logic [31:0]                 core_control_class,
   input  wire logic                        pointer_step_enable,
   // Serial link from the host
   input  wire logic                        sck,
   input  wire logic                        cs_n,
   input  wire logic                        si,
   output logic                             so,
   output logic                             so_oe_n,
   // Register updates and soft reset, system clock
   output logic                             upd_valid,
   output ecd_pkg::ecd_update_t             upd,
   output logic                             soft_reset_pulse
);

   // ==========================================================
   // Elaboration checks
   initial begin
      if (MEM_DEPTH != (1 << ecd_pkg::PTR_W)) begin
         $error("MEM_DEPTH must match the 13-bit buffer pointers");
      end
      if (NUM_BANKS != (1 << ecd_pkg::BANK_W)) begin
         $error("NUM_BANKS must match the bank select width");
      end
   end

   localparam int unsigned PW = ecd_pkg::PTR_W;

   // ==========================================================
   // Storage in the link domain
   logic [7:0] buf_mem  [MEM_DEPTH];
   logic [7:0] reg_file [NUM_BANKS][32];

   // Frame state, cleared whenever chip select is high.
   ecd_pkg::ecd_phase_t phase_q,   phase_d;
   logic [2:0]          bit_cnt_q, bit_cnt_d;
   logic [6:0]          sh_in_q,   sh_in_d;
   logic [2:0]          opc_q,     opc_d;
   logic [4:0]          arg_q,     arg_d;
   logic [7:0]          tx_byte_q, tx_byte_d;

   // Pointers survive across frames.
   logic [PW-1:0] rd_ptr_q,  rd_ptr_d;
   logic [PW-1:0] wr_ptr_q,  wr_ptr_d;
   logic [PW-1:0] rx_st_q,   rx_st_d;
   logic [PW-1:0] rx_end_q,  rx_end_d;

   // Synchronised configuration.
   logic [ecd_pkg::BANK_W-1:0] bank_s;
   logic [31:0]                class_s;
   logic                       step_s;

   // Write strobes and event words.
   logic        mem_we;
   logic        reg_we;
   logic [7:0]  reg_val;
   logic        upd_fire;
   logic        srst_fire;
   logic [7:0]  byte_in;
   logic        last_bit;
   logic [7:0]  cur_reg;
   logic [4:0]  cmd_arg;
   logic [2:0]  cmd_opc;
   logic [PW-1:0] rd_next;
   ecd_pkg::ecd_update_t upd_word;

   // Quasi-static settings; the host leaves them alone during a frame.
   ecd_sync #(.WIDTH(ecd_pkg::BANK_W + 33)) u_cfg_sync (
      .clk   (sck),
      .reset (reset),
      .d     ({bank_sel, core_control_class, pointer_step_enable}),
      .q     ({bank_s, class_s, step_s})
   );

   // ==========================================================
   // Register read mux; the pointers live in flops, not in the array.
   function automatic logic [7:0] read_reg(input logic [1:0] bk, input logic [4:0] a,
                                           input logic [7:0] arr_val);
      logic [7:0] r;
      r = arr_val;
      if (bk == ecd_pkg::PTR_BANK) begin
         case (a)
            ecd_pkg::OFS_RD_LO:  r = rd_ptr_q[7:0];
            ecd_pkg::OFS_RD_HI:  r = {3'h0, rd_ptr_q[PW-1:8]};
            ecd_pkg::OFS_WR_LO:  r = wr_ptr_q[7:0];
            ecd_pkg::OFS_WR_HI:  r = {3'h0, wr_ptr_q[PW-1:8]};
            ecd_pkg::OFS_RXS_LO: r = rx_st_q[7:0];
            ecd_pkg::OFS_RXS_HI: r = {3'h0, rx_st_q[PW-1:8]};
            ecd_pkg::OFS_RXE_LO: r = rx_end_q[7:0];
            ecd_pkg::OFS_RXE_HI: r = {3'h0, rx_end_q[PW-1:8]};
            default:             r = arr_val;
         endcase
      end
      return r;
   endfunction

   // Completed byte and the command fields it carries.
   always_comb begin
      byte_in  = {sh_in_q, si};                                         // [R2]
      last_bit = (bit_cnt_q == ecd_pkg::BIT_LAST);
      cmd_opc  = byte_in[7:5];                                          // [R1]
      cmd_arg  = byte_in[4:0];
   end

   // Register addressed by the argument within the current bank.
   always_comb begin
      if (phase_q == ecd_pkg::PH_CMD) begin
         cur_reg = read_reg(bank_s, cmd_arg, reg_file[bank_s][cmd_arg]); // [R4]
      end else begin
         cur_reg = read_reg(bank_s, arg_q, reg_file[bank_s][arg_q]);    // [R22]
      end
   end

   // Next read address; ring end takes priority over the top wrap.
   always_comb begin
      if (rd_ptr_q == rx_end_q) begin
         rd_next = rx_st_q;                                             // [R10]
      end else if (rd_ptr_q == ecd_pkg::PTR_TOP) begin
         rd_next = ecd_pkg::PTR_ZERO;                                   // [R11]
      end else begin
         rd_next = rd_ptr_q + ecd_pkg::PTR_ONE;
      end
   end

   // ==========================================================
   // Command decoder, next state
   always_comb begin
      phase_d   = phase_q;
      bit_cnt_d = bit_cnt_q + 3'h1;
      sh_in_d   = byte_in[6:0];
      opc_d     = opc_q;
      arg_d     = arg_q;
      tx_byte_d = tx_byte_q;
      rd_ptr_d  = rd_ptr_q;
      wr_ptr_d  = wr_ptr_q;
      rx_st_d   = rx_st_q;
      rx_end_d  = rx_end_q;
      mem_we    = 1'b0;
      reg_we    = 1'b0;
      reg_val   = cur_reg;
      upd_fire  = 1'b0;
      srst_fire = 1'b0;
      // Nothing acts before the eighth bit, so a short byte is dropped.
      if (last_bit) begin                                               // [R13] [R20]
         case (phase_q)
            ecd_pkg::PH_CMD: begin
               opc_d = cmd_opc;
               arg_d = cmd_arg;
               case (cmd_opc)
                  ecd_pkg::OPC_REG_READ: begin
                     if (class_s[cmd_arg]) begin                        // [R23]
                        phase_d   = ecd_pkg::PH_DATA;
                        tx_byte_d = cur_reg;                            // [R5]
                     end else begin
                        phase_d   = ecd_pkg::PH_DUMMY;
                        tx_byte_d = ecd_pkg::DUMMY_BYTE;                // [R6]
                     end
                  end
                  ecd_pkg::OPC_BUF_READ: begin
                     phase_d   = ecd_pkg::PH_DATA;
                     tx_byte_d = buf_mem[rd_ptr_q];                     // [R8]
                  end
                  ecd_pkg::OPC_REG_WRITE,
                  ecd_pkg::OPC_BUF_WRITE,
                  ecd_pkg::OPC_BIT_SET,
                  ecd_pkg::OPC_BIT_CLEAR: begin
                     phase_d = ecd_pkg::PH_DATA;
                  end
                  ecd_pkg::OPC_SOFT_RST: begin
                     phase_d   = ecd_pkg::PH_IDLE;
                     srst_fire = (cmd_arg == ecd_pkg::ARG_SOFT_RST);    // [R21]
                  end
                  default: begin
                     phase_d = ecd_pkg::PH_IDLE;
                  end
               endcase
            end
            ecd_pkg::PH_DUMMY: begin
               phase_d   = ecd_pkg::PH_DATA;
               tx_byte_d = cur_reg;                                     // [R6]
            end
            ecd_pkg::PH_DATA: begin
               case (opc_q)
                  ecd_pkg::OPC_REG_READ: begin
                     tx_byte_d = cur_reg;
                  end
                  ecd_pkg::OPC_BUF_READ: begin
                     // Step after the last bit; the next byte goes out next.
                     if (step_s) begin
                        rd_ptr_d  = rd_next;                            // [R9]
                        tx_byte_d = buf_mem[rd_next];
                     end else begin
                        tx_byte_d = buf_mem[rd_ptr_q];                  // [R8]
                     end
                  end
                  ecd_pkg::OPC_BUF_WRITE: begin
                     mem_we = 1'b1;                                     // [R14] [R16]
                     if (step_s) begin
                        wr_ptr_d = (wr_ptr_q == ecd_pkg::PTR_TOP) ?
                                   ecd_pkg::PTR_ZERO :                  // [R15]
                                   wr_ptr_q + ecd_pkg::PTR_ONE;         // [R14]
                     end
                  end
                  ecd_pkg::OPC_REG_WRITE: begin
                     reg_we  = 1'b1;
                     reg_val = byte_in;                                 // [R12]
                  end
                  ecd_pkg::OPC_BIT_SET: begin
                     reg_we  = 1'b1;
                     reg_val = cur_reg | byte_in;                       // [R17]
                  end
                  ecd_pkg::OPC_BIT_CLEAR: begin
                     reg_we  = 1'b1;
                     reg_val = cur_reg & ~byte_in;                      // [R18]
                  end
                  default: begin
                     phase_d = ecd_pkg::PH_IDLE;
                  end
               endcase
            end
            ecd_pkg::PH_IDLE: begin
               phase_d = ecd_pkg::PH_IDLE;
            end
            default: begin
               phase_d = ecd_pkg::PH_IDLE;
            end
         endcase
      end
      // Pointer bytes are kept in flops; a write there retargets them.
      if (reg_we) begin
         upd_fire = 1'b1;
         if (bank_s == ecd_pkg::PTR_BANK) begin
            case (arg_q)
               ecd_pkg::OFS_RD_LO:  rd_ptr_d[7:0]    = reg_val;
               ecd_pkg::OFS_RD_HI:  rd_ptr_d[PW-1:8] = reg_val[4:0];
               ecd_pkg::OFS_WR_LO:  wr_ptr_d[7:0]    = reg_val;
               ecd_pkg::OFS_WR_HI:  wr_ptr_d[PW-1:8] = reg_val[4:0];
               ecd_pkg::OFS_RXS_LO: rx_st_d[7:0]     = reg_val;
               ecd_pkg::OFS_RXS_HI: rx_st_d[PW-1:8]  = reg_val[4:0];
               ecd_pkg::OFS_RXE_LO: rx_end_d[7:0]    = reg_val;
               ecd_pkg::OFS_RXE_HI: rx_end_d[PW-1:8] = reg_val[4:0];
               default: begin
               end
            endcase
         end
      end
      upd_word.bank  = bank_s;
      upd_word.addr  = arg_q;
      upd_word.value = reg_val;
   end

   // ==========================================================
   // Frame flops: chip select high clears them, so a frame always starts
   // on the command byte even if the host stopped mid-byte.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin                                                   // [R3]
         phase_q   <= ecd_pkg::PH_CMD;
         bit_cnt_q <= 3'h0;
         sh_in_q   <= 7'h00;
         opc_q     <= ecd_pkg::OPC_REG_READ;
         arg_q     <= 5'h00;
         tx_byte_q <= ecd_pkg::DUMMY_BYTE;
      end else begin
         phase_q   <= phase_d;
         bit_cnt_q <= bit_cnt_d;
         sh_in_q   <= sh_in_d;
         opc_q     <= opc_d;
         arg_q     <= arg_d;
         tx_byte_q <= tx_byte_d;
      end
   end

   // Pointer flops, cleared only by the system reset.
   always_ff @(posedge sck or posedge reset) begin
      if (reset) begin
         rd_ptr_q <= ecd_pkg::RST_RD_PTR;
         wr_ptr_q <= ecd_pkg::RST_WR_PTR;
         rx_st_q  <= ecd_pkg::RST_RXS;
         rx_end_q <= ecd_pkg::RST_RXE;
      end else begin
         rd_ptr_q <= rd_ptr_d;
         wr_ptr_q <= wr_ptr_d;
         rx_st_q  <= rx_st_d;
         rx_end_q <= rx_end_d;
      end
   end

   // Memories have no reset; they hold whatever the host stored.
   always_ff @(posedge sck) begin
      if (mem_we && !cs_n) begin
         buf_mem[wr_ptr_q] <= byte_in;                                  // [R14]
      end
      if (reg_we && !cs_n) begin
         reg_file[bank_s][arg_q] <= reg_val;                            // [R12] [R17] [R18]
      end
   end

   // ==========================================================
   // Output on the falling edge: bit 7 first, half a clock ahead of the
   // host's sampling edge.
   logic so_q, so_d;
   logic oe_n_q;

   always_comb begin
      so_d = tx_byte_q[ecd_pkg::BIT_LAST - bit_cnt_q];                  // [R2] [R5]
   end

   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so_q   <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         so_q   <= so_d;
         oe_n_q <= 1'b0;
      end
   end

   assign so      = so_q;
   assign so_oe_n = oe_n_q;

   // ==========================================================
   // Crossings to the system clock
   ecd_event_xfer #(.WIDTH(ecd_pkg::UPD_W)) u_upd_xfer (
      .reset     (reset),
      .clk_src   (sck),
      .src_fire  (upd_fire && !cs_n),
      .src_data  (upd_word),
      .clk_dst   (clk_sys),
      .dst_valid (upd_valid),
      .dst_data  (upd)
   );

   ecd_event_xfer #(.WIDTH(1)) u_srst_xfer (
      .reset     (reset),
      .clk_src   (sck),
      .src_fire  (srst_fire && !cs_n),                                  // [R21]
      .src_data  (1'b1),
      .clk_dst   (clk_sys),
      .dst_valid (soft_reset_pulse),
      .dst_data  ()
   );

endmodule

`default_nettype wire

// ---- verif/ecd_spi_decoder_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker for the command decoder, all on the system clock.
module ecd_spi_decoder_asserts (
   // System clock and reset
   input wire logic                 clk_sys,
   input wire logic                 reset,
   // Configuration
   input wire logic [1:0]           bank_sel,
   input wire logic [31:0]          core_control_class,
   input wire logic                 pointer_step_enable,
   // Serial link
   input wire logic                 sck,
   input wire logic                 cs_n,
   input wire logic                 si,
   input wire logic                 so,
   input wire logic                 so_oe_n,
   // System side events
   input wire logic                 upd_valid,
   input wire ecd_pkg::ecd_update_t upd,
   input wire logic                 soft_reset_pulse
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Link output rules; sck is slow enough to be seen low after each falling edge.
   a_idle_quiet: assert property (cs_n |-> so_oe_n && !so)
      else $error("Output driven outside a frame.");
   a_so_fall: assert property (!cs_n && $changed(so) |-> !sck)
      else $error("Output bit moved while clock high.");
   a_oe_fall: assert property ($fell(so_oe_n) |-> !sck && !cs_n)
      else $error("Output enabled off a falling edge.");
   // Event rules; one byte lasts far longer than four system clocks.
   a_upd_gap: assert property (upd_valid |=> !upd_valid [*3])
      else $error("Update pulses too close.");
   a_upd_hold: assert property ($changed(upd) |-> upd_valid)
      else $error("Update word moved without a pulse.");
   a_upd_bank: assert property (upd_valid |-> upd.bank == bank_sel)
      else $error("Update carries the wrong bank.");
   a_srst_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("Soft reset pulse too long.");
   a_srst_alone: assert property (soft_reset_pulse |-> !upd_valid)
      else $error("Soft reset touched a register.");
endmodule

bind ecd_spi_decoder ecd_spi_decoder_asserts u_asserts (
   .clk_sys(clk_sys), .reset(reset), .bank_sel(bank_sel),
   .core_control_class(core_control_class), .pointer_step_enable(pointer_step_enable),
   .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
   .upd_valid(upd_valid), .upd(upd), .soft_reset_pulse(soft_reset_pulse)
);

`default_nettype wire

// ---- verif/ecd_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host model: mode 0 master, clock stands low outside frames.
module ecd_host (
   // Link outputs
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   // Link input
   input  wire logic so
);
   // Idle link; select rises so frame flops clear.
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
      #0.5 cs_n = 1'b1;
   end

   // The offset keeps link edges clear of system clock edges.
   task automatic frame_open();
      #1.3 cs_n = 1'b0;
      #7.5;
   endtask

   // MSB first; data set while sck is low, reply taken on the rising edge.
   task automatic xfer(input logic [7:0] tx, input int bits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - bits; i--) begin
         si = tx[i];
         #7.5 sck = 1'b1;
         rx[i] = so;
         #7.5 sck = 1'b0;
      end
   endtask

   // Released data line shows the inverse of its last bit.
   task automatic frame_close();
      #7.5 cs_n = 1'b1;
      si = ~si;
      #30;
   endtask
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the command decoder.
module tb;
   logic                 clk_sys = 1'b0;
   logic                 reset = 1'b0;
   logic [1:0]           bank_sel = 2'h1;
   logic [31:0]          core_control_class = 32'h00000020;
   logic                 pointer_step_enable = 1'b1;
   logic                 sck, cs_n, si, so, so_oe_n, upd_valid, soft_reset_pulse;
   ecd_pkg::ecd_update_t upd, upd_seen;
   logic [7:0]           txb [4];
   logic [7:0]           rxb [4];
   int                   error_cnt = 0, tests_run = 0, upd_cnt = 0, srst_cnt = 0, cyc = 0;

   // Clock.
   always #2.5 clk_sys = ~clk_sys;

   ecd_spi_decoder DUT (
      .clk_sys(clk_sys), .reset(reset), .bank_sel(bank_sel),
      .core_control_class(core_control_class), .pointer_step_enable(pointer_step_enable),
      .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
      .upd_valid(upd_valid), .upd(upd), .soft_reset_pulse(soft_reset_pulse));
   ecd_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

   // Pulses are counted here so no scenario can miss a one-cycle event.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (upd_valid === 1'b1) begin
         upd_cnt <= upd_cnt + 1;
         upd_seen <= upd;
      end
      if (soft_reset_pulse === 1'b1) srst_cnt <= srst_cnt + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end

   // Comparison.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %0h, want %0h", $time, seen, exp);
      end
   endtask

   // Verdict.
   task automatic complete_run();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One framed command; the last data byte may be cut short.
   task automatic frame(input logic [7:0] b0, input int n, input int bits);
      logic [7:0] rx;
      host.frame_open();
      host.xfer(b0, 8, rx);
      for (int i = 0; i < n; i++) begin
         host.xfer(txb[i], (i == n - 1) ? bits : 8, rxb[i]);
      end
      host.frame_close();
      repeat (10) @(posedge clk_sys);
   endtask

   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      txb[0] = d;
      frame({ecd_pkg::OPC_REG_WRITE, a}, 1, 8);
   endtask

   // Register write, core read, non-core read with its dummy byte.
   task automatic t_reg();
      int n;
      n = upd_cnt;
      wreg(5'h05, 8'hA5);
      check(upd_cnt - n, 1);
      check(upd_seen, {2'h1, 5'h05, 8'hA5});
      frame({ecd_pkg::OPC_REG_READ, 5'h05}, 1, 8);
      check(rxb[0], 8'hA5);
      wreg(5'h06, 8'h3C);
      frame({ecd_pkg::OPC_REG_READ, 5'h06}, 2, 8);
      check(rxb[0], 8'h00);
      check(rxb[1], 8'h3C);
      check(so_oe_n, 1'b1);
   endtask

   // Set and clear on a core register, then cut-short bytes change nothing.
   task automatic t_bits();
      int n;
      wreg(5'h05, 8'hF1);
      txb[0] = 8'h17;
      frame({ecd_pkg::OPC_BIT_CLEAR, 5'h05}, 1, 8); // Core register only.
      check(upd_seen, {2'h1, 5'h05, 8'hE0});
      txb[0] = 8'h0A;
      frame({ecd_pkg::OPC_BIT_SET, 5'h05}, 1, 8);
      check(upd_seen, {2'h1, 5'h05, 8'hEA});
      n = upd_cnt;
      txb[0] = 8'hFF;
      frame({ecd_pkg::OPC_REG_WRITE, 5'h05}, 1, 7);
      frame({ecd_pkg::OPC_BIT_CLEAR, 5'h05}, 1, 5);
      check(upd_cnt - n, 0);
      frame({ecd_pkg::OPC_REG_READ, 5'h05}, 1, 8);
      check(rxb[0], 8'hEA);
      frame({ecd_pkg::OPC_REG_READ, 5'h06}, 2, 8);
      check(rxb[1], 8'h3C);
   endtask

   // Buffer stream across the top address and the ring end.
   task automatic t_buf();
      logic [4:0]  ofs [4];
      logic [12:0] val [4];
      ofs = '{ecd_pkg::OFS_RD_LO, ecd_pkg::OFS_WR_LO, ecd_pkg::OFS_RXS_LO, ecd_pkg::OFS_RXE_LO};
      val = '{13'h1FFE, 13'h1FFE, 13'h1FFE, 13'h0000};
      #1 bank_sel = ecd_pkg::PTR_BANK;
      for (int i = 0; i < 4; i++) begin
         wreg(ofs[i], val[i][7:0]);
         wreg(ofs[i] + 5'h01, {3'h0, val[i][12:8]});
      end
      txb = '{8'h11, 8'h22, 8'h33, 8'h44};
      frame({ecd_pkg::OPC_BUF_WRITE, ecd_pkg::ARG_BUF}, 3, 8);
      frame({ecd_pkg::OPC_BUF_READ, ecd_pkg::ARG_BUF}, 4, 8);
      check(rxb[0], 8'h11);
      check(rxb[1], 8'h22);
      check(rxb[2], 8'h33);
      check(rxb[3], 8'h11);
      check(rxb[2], 8'h33);
      #1 pointer_step_enable = 1'b0;
      frame({ecd_pkg::OPC_BUF_READ, ecd_pkg::ARG_BUF}, 2, 8);
      check(rxb[0], 8'h22);
      check(rxb[1], 8'h22);
      #1 pointer_step_enable = 1'b1;
   endtask

   // Soft reset, then a wrong constant that must be ignored.
   task automatic t_srst();
      int n, m;
      n = srst_cnt;
      m = upd_cnt;
      frame({ecd_pkg::OPC_SOFT_RST, ecd_pkg::ARG_SOFT_RST}, 0, 8);
      check(srst_cnt - n, 1);
      check(upd_cnt - m, 0);
      frame({ecd_pkg::OPC_SOFT_RST, 5'h1E}, 0, 8);
      check(srst_cnt - n, 1);
   endtask

   // Main sequence.
   initial begin
      #1 reset = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 reset = 1'b0;
      repeat (2) @(posedge clk_sys);
      t_reg();
      t_bits();
      t_buf();
      t_srst();
      complete_run();
   end
endmodule

`default_nettype wire
